// ### rtl/bit_branch_cpu_control.sv
// Functional notes
// - short-direct bit set: branch by 3 or 4
// - special-register bit set: branch by 4
// - accumulator or status bit set: branch by 3
// - absolute or indirect bit set: branch by 3
// - short-direct set bit: clear it, branch 4/5
// - special-register set bit: clear, branch 4, atomic
// - accumulator set bit: clear it, branch 3
// - high status set bit: clear it, branch 3
// - low status writes update the arithmetic flags
// - short-direct clear bit: set it, branch 4/5
// - special-register clear bit: set it, branch 4
// - accumulator clear bit: set it, branch 3
// - high status clear bit: set it, branch 3
// - B/C decrement, branch by 2 if nonzero
// - short-direct byte decrement, branch 3/4 if nonzero
// - plain bank select: alternate set off, load bank
// - alternate bank select: alternate set on, load bank
// - enable instruction sets interrupt enable
// - disable instruction clears interrupt enable
// - location instruction loads upper address word
module bit_branch_cpu_control (
  input logic CLK_I,
  input logic SYS_RST_I,
  input logic INSTR_VALID_I,
  input bit_branch_pkg::instr_s INSTR_I,
  output logic INSTR_READY_O,
  output bit_branch_pkg::reg_sel_e REG_SEL_O,
  input logic [7:0] REG_RD_DATA_I,
  output logic REG_WR_O,
  output logic [7:0] REG_WR_DATA_O,
  output logic MEM_REQ_O,
  output logic MEM_WE_O,
  output logic MEM_LOCK_O,
  output logic MEM_SFR_O,
  output logic [bit_branch_pkg::ADDR_W-1:0] MEM_ADDR_O,
  output logic [7:0] MEM_WDATA_O,
  input logic [7:0] MEM_RDATA_I,
  input logic MEM_ACK_I,
  input logic STATUS_LOAD_I,
  input logic [15:0] STATUS_LOAD_DATA_I,
  output logic [7:0] STATUS_WORD_LOW_O,
  output logic [7:0] STATUS_WORD_HIGH_O,
  output logic GLOBAL_INTERRUPT_ENABLE_O,
  output logic [2:0] REGISTER_BANK_FIELD_O,
  output logic ALT_REGISTER_SET_SELECT_O,
  output logic [bit_branch_pkg::LOC_W-1:0] LOCATION_WORD_O,
  output logic DONE_O,
  output logic BRANCH_TAKEN_O,
  output logic [bit_branch_pkg::PC_W-1:0] NEXT_PC_O
);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_READ,
    ST_EXEC,
    ST_WRITE
  } state_e;

  state_e state_q;
  state_e state_d;
  bit_branch_pkg::instr_s instr_q;
  logic [7:0] mem_data_q;
  logic [7:0] wdata_q;
  logic [7:0] status_low_q;
  logic [7:0] status_high_q;
  logic int_enable_q;
  logic [2:0] bank_q;
  logic alt_set_q;
  logic [bit_branch_pkg::LOC_W-1:0] loc_q;
  logic done_q;
  logic taken_q;
  logic [bit_branch_pkg::PC_W-1:0] next_pc_q;
  logic reg_wr_q;
  logic [7:0] reg_wr_data_q;

  logic accept;
  logic mem_operand;
  logic reg_operand;
  logic [7:0] operand;
  logic eval_taken;
  logic eval_write;
  logic [7:0] eval_byte;
  logic [bit_branch_pkg::PC_W-1:0] eval_target;
  logic exec_status_low_wr;
  logic exec_status_high_wr;
  logic exec_mem_wr;
  logic [bit_branch_pkg::PC_W-1:0] seq_pc;

  assign accept = (state_q == ST_IDLE) && INSTR_VALID_I;
  assign INSTR_READY_O = (state_q == ST_IDLE);

  function automatic logic is_mem(input bit_branch_pkg::opd_e opd);
    is_mem = (opd == bit_branch_pkg::OPD_SHORT_DIRECT) ||
             (opd == bit_branch_pkg::OPD_SPECIAL_FUNC) ||
             (opd == bit_branch_pkg::OPD_ABS16) ||
             (opd == bit_branch_pkg::OPD_ABS24) ||
             (opd == bit_branch_pkg::OPD_INDIRECT_MEMORY_OPERAND);
  endfunction

  function automatic logic is_data_op(input bit_branch_pkg::op_e op);
    is_data_op = (op == bit_branch_pkg::OP_BRANCH_IF_BIT_SET) ||
                 (op == bit_branch_pkg::OP_BRANCH_IF_BIT_CLEAR) ||
                 (op == bit_branch_pkg::OP_BRANCH_IF_SET_AND_CLEAR) ||
                 (op == bit_branch_pkg::OP_BRANCH_IF_CLEAR_AND_SET) ||
                 (op == bit_branch_pkg::OP_DECREMENT_BRANCH_NONZERO);
  endfunction

  assign mem_operand = is_data_op(instr_q.op) && is_mem(instr_q.opd);
  assign reg_operand = is_data_op(instr_q.op) &&
                       ((instr_q.opd == bit_branch_pkg::OPD_ACC_X) ||
                        (instr_q.opd == bit_branch_pkg::OPD_ACC_A) ||
                        (instr_q.opd == bit_branch_pkg::OPD_COUNT_B) ||
                        (instr_q.opd == bit_branch_pkg::OPD_COUNT_C));

  always_comb
  begin
    REG_SEL_O = bit_branch_pkg::REG_A;
    unique case (instr_q.opd)
      bit_branch_pkg::OPD_ACC_X: REG_SEL_O = bit_branch_pkg::REG_X;
      bit_branch_pkg::OPD_COUNT_B: REG_SEL_O = bit_branch_pkg::REG_B;
      bit_branch_pkg::OPD_COUNT_C: REG_SEL_O = bit_branch_pkg::REG_C;
      default: REG_SEL_O = bit_branch_pkg::REG_A;
    endcase
  end

  always_comb
  begin
    operand = REG_RD_DATA_I;
    if (mem_operand)
    begin
      operand = mem_data_q;
    end
    else if (instr_q.opd == bit_branch_pkg::OPD_STATUS_LOW)
    begin
      operand = status_low_q;
    end
    else if (instr_q.opd == bit_branch_pkg::OPD_STATUS_HIGH)
    begin
      operand = status_high_q;
    end
  end

  branch_eval u_eval (
    .op_i(instr_q.op),
    .opd_i(instr_q.opd),
    .long_enc_i(instr_q.long_enc),
    .bit_idx_i(instr_q.bit_idx),
    .operand_i(operand),
    .disp_i(instr_q.branch_displacement_8),
    .pc_i(instr_q.pc),
    .taken_o(eval_taken),
    .write_o(eval_write),
    .new_byte_o(eval_byte),
    .target_o(eval_target)
  );

  assign seq_pc = instr_q.pc + {{(bit_branch_pkg::PC_W-bit_branch_pkg::LEN_W){1'b0}}, instr_q.len};
  assign exec_mem_wr = (state_q == ST_EXEC) && mem_operand && eval_write;
  assign exec_status_low_wr = (state_q == ST_EXEC) && is_data_op(instr_q.op) && eval_write &&
                              (instr_q.opd == bit_branch_pkg::OPD_STATUS_LOW);
  assign exec_status_high_wr = (state_q == ST_EXEC) && is_data_op(instr_q.op) && eval_write &&
                               (instr_q.opd == bit_branch_pkg::OPD_STATUS_HIGH);

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE:
      begin
        if (INSTR_VALID_I)
        begin
          state_d = (is_data_op(INSTR_I.op) && is_mem(INSTR_I.opd)) ? ST_READ : ST_EXEC;
        end
      end
      ST_READ:
      begin
        if (MEM_ACK_I)
        begin
          state_d = ST_EXEC;
        end
      end
      ST_EXEC: state_d = exec_mem_wr ? ST_WRITE : ST_IDLE;
      ST_WRITE:
      begin
        if (MEM_ACK_I)
        begin
          state_d = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I)
    begin
      state_q <= ST_IDLE;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I)
    begin
      instr_q <= '0;
    end
    else if (accept)
    begin
      instr_q <= INSTR_I;
    end
  end

  // memory bus held locked from read through write-back
  assign MEM_REQ_O = (state_q == ST_READ) || (state_q == ST_WRITE);
  assign MEM_WE_O = (state_q == ST_WRITE);
  assign MEM_LOCK_O = (state_q == ST_READ) || (state_q == ST_EXEC && mem_operand) ||
                      (state_q == ST_WRITE);
  assign MEM_SFR_O = (instr_q.opd == bit_branch_pkg::OPD_SPECIAL_FUNC);
  assign MEM_ADDR_O = instr_q.addr;
  assign MEM_WDATA_O = wdata_q;

  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I)
    begin
      mem_data_q <= 8'h00;
    end
    else if (state_q == ST_READ && MEM_ACK_I)
    begin
      mem_data_q <= MEM_RDATA_I;
    end
  end

  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I)
    begin
      wdata_q <= 8'h00;
    end
    else if (exec_mem_wr)
    begin
      wdata_q <= eval_byte;
    end
  end

  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I)
    begin
      reg_wr_q <= 1'b0;
      reg_wr_data_q <= 8'h00;
    end
    else
    begin
      reg_wr_q <= (state_q == ST_EXEC) && reg_operand && eval_write;
      if ((state_q == ST_EXEC) && reg_operand)
      begin
        reg_wr_data_q <= eval_byte;
      end
    end
  end

  assign REG_WR_O = reg_wr_q;
  assign REG_WR_DATA_O = reg_wr_data_q;

  // instruction write beats an outside load landing in the same cycle
  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I)
    begin
      status_low_q <= bit_branch_pkg::STATUS_LOW_RST;
    end
    else if (exec_status_low_wr)
    begin
      status_low_q <= eval_byte;
    end
    else if (STATUS_LOAD_I)
    begin
      status_low_q <= STATUS_LOAD_DATA_I[7:0];
    end
  end

  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I)
    begin
      status_high_q <= bit_branch_pkg::STATUS_HIGH_RST;
    end
    else if (exec_status_high_wr)
    begin
      status_high_q <= eval_byte;
    end
    else if (STATUS_LOAD_I)
    begin
      status_high_q <= STATUS_LOAD_DATA_I[15:8];
    end
  end

  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I)
    begin
      int_enable_q <= bit_branch_pkg::INT_ENABLE_RST;
      bank_q <= bit_branch_pkg::BANK_RST;
      alt_set_q <= bit_branch_pkg::ALT_SET_RST;
      loc_q <= bit_branch_pkg::LOCATION_RST;
    end
    else if (state_q == ST_EXEC)
    begin
      unique case (instr_q.op)
        bit_branch_pkg::OP_BANK_SELECT:
        begin
          alt_set_q <= 1'b0;
          bank_q <= instr_q.bank;
        end
        bit_branch_pkg::OP_BANK_SELECT_ALT:
        begin
          alt_set_q <= 1'b1;
          bank_q <= instr_q.bank;
        end
        bit_branch_pkg::OP_INTERRUPT_ENABLE_INSTR: int_enable_q <= 1'b1;
        bit_branch_pkg::OP_INTERRUPT_DISABLE_INSTR: int_enable_q <= 1'b0;
        bit_branch_pkg::OP_LOCATION: loc_q <= instr_q.loc;
        default:
        begin
          loc_q <= loc_q;
        end
      endcase
    end
  end

  assign GLOBAL_INTERRUPT_ENABLE_O = int_enable_q;
  assign REGISTER_BANK_FIELD_O = bank_q;
  assign ALT_REGISTER_SET_SELECT_O = alt_set_q;
  assign LOCATION_WORD_O = loc_q;
  assign STATUS_WORD_LOW_O = status_low_q;
  assign STATUS_WORD_HIGH_O = status_high_q;

  // pc result prepared in exec so a pending write-back only delays the pulse
  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I)
    begin
      taken_q <= 1'b0;
      next_pc_q <= '0;
    end
    else if (state_q == ST_EXEC)
    begin
      taken_q <= eval_taken;
      next_pc_q <= eval_taken ? eval_target : seq_pc;
    end
  end

  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I)
    begin
      done_q <= 1'b0;
    end
    else
    begin
      done_q <= ((state_q == ST_EXEC) && !exec_mem_wr) ||
                ((state_q == ST_WRITE) && MEM_ACK_I);
    end
  end

  assign DONE_O = done_q;
  assign BRANCH_TAKEN_O = taken_q;
  assign NEXT_PC_O = next_pc_q;

endmodule

// ### inc/bit_branch_pkg.sv
package bit_branch_pkg;

  localparam int PC_W = 20;
  localparam int ADDR_W = 24;
  localparam int LOC_W = 8;
  localparam int LEN_W = 3;
  localparam int OFS_W = 3;

  // branch base offsets, before the long-encoding increment
  localparam logic [OFS_W-1:0] OFS_COUNT_REG = 3'h2;
  localparam logic [OFS_W-1:0] OFS_SHORT = 3'h3;
  localparam logic [OFS_W-1:0] OFS_SHORT_MODIFY = 3'h4;
  localparam logic [OFS_W-1:0] OFS_SPECIAL = 3'h4;
  localparam logic [OFS_W-1:0] OFS_OTHER = 3'h3;

  localparam logic [7:0] STATUS_LOW_RST = 8'h00;
  localparam logic [7:0] STATUS_HIGH_RST = 8'h00;
  localparam logic [2:0] BANK_RST = 3'h0;
  localparam logic ALT_SET_RST = 1'b0;
  localparam logic INT_ENABLE_RST = 1'b0;
  localparam logic [LOC_W-1:0] LOCATION_RST = 8'h00;

  typedef enum logic [3:0] {
    OP_BRANCH_IF_BIT_SET,
    OP_BRANCH_IF_BIT_CLEAR,
    OP_BRANCH_IF_SET_AND_CLEAR,
    OP_BRANCH_IF_CLEAR_AND_SET,
    OP_DECREMENT_BRANCH_NONZERO,
    OP_BANK_SELECT,
    OP_BANK_SELECT_ALT,
    OP_INTERRUPT_ENABLE_INSTR,
    OP_INTERRUPT_DISABLE_INSTR,
    OP_LOCATION
  } op_e;

  typedef enum logic [3:0] {
    OPD_SHORT_DIRECT,
    OPD_SPECIAL_FUNC,
    OPD_ACC_X,
    OPD_ACC_A,
    OPD_STATUS_LOW,
    OPD_STATUS_HIGH,
    OPD_ABS16,
    OPD_ABS24,
    OPD_INDIRECT_MEMORY_OPERAND,
    OPD_COUNT_B,
    OPD_COUNT_C
  } opd_e;

  typedef enum logic [1:0] {
    REG_X,
    REG_A,
    REG_B,
    REG_C
  } reg_sel_e;

  typedef struct packed {
    op_e op;
    opd_e opd;
    logic long_enc;
    logic [2:0] bit_idx;
    logic [LEN_W-1:0] len;
    logic [7:0] branch_displacement_8;
    logic [ADDR_W-1:0] addr;
    logic [PC_W-1:0] pc;
    logic [2:0] bank;
    logic [LOC_W-1:0] loc;
  } instr_s;

endpackage

// ### rtl/branch_eval.sv
module branch_eval (
  input bit_branch_pkg::op_e op_i,
  input bit_branch_pkg::opd_e opd_i,
  input logic long_enc_i,
  input logic [2:0] bit_idx_i,
  input logic [7:0] operand_i,
  input logic [7:0] disp_i,
  input logic [bit_branch_pkg::PC_W-1:0] pc_i,
  output logic taken_o,
  output logic write_o,
  output logic [7:0] new_byte_o,
  output logic [bit_branch_pkg::PC_W-1:0] target_o
);

  logic bit_val;
  logic [7:0] dec_val;
  logic [bit_branch_pkg::OFS_W-1:0] ofs;
  logic modify_op;

  assign bit_val = operand_i[bit_idx_i];
  assign dec_val = operand_i - 8'h01;
  assign modify_op = (op_i == bit_branch_pkg::OP_BRANCH_IF_SET_AND_CLEAR) ||
                     (op_i == bit_branch_pkg::OP_BRANCH_IF_CLEAR_AND_SET);

  always_comb
  begin
    taken_o = 1'b0;
    write_o = 1'b0;
    new_byte_o = operand_i;
    unique case (op_i)
      bit_branch_pkg::OP_BRANCH_IF_BIT_SET: taken_o = bit_val;
      bit_branch_pkg::OP_BRANCH_IF_BIT_CLEAR: taken_o = !bit_val;
      bit_branch_pkg::OP_BRANCH_IF_SET_AND_CLEAR:
      begin
        // bit untouched when not taken
        taken_o = bit_val;
        write_o = bit_val;
        new_byte_o[bit_idx_i] = 1'b0;
      end
      bit_branch_pkg::OP_BRANCH_IF_CLEAR_AND_SET:
      begin
        taken_o = !bit_val;
        write_o = !bit_val;
        new_byte_o[bit_idx_i] = 1'b1;
      end
      bit_branch_pkg::OP_DECREMENT_BRANCH_NONZERO:
      begin
        // counter written back even when the branch falls through
        new_byte_o = dec_val;
        write_o = 1'b1;
        taken_o = (dec_val != 8'h00);
      end
      bit_branch_pkg::OP_BANK_SELECT,
      bit_branch_pkg::OP_BANK_SELECT_ALT,
      bit_branch_pkg::OP_INTERRUPT_ENABLE_INSTR,
      bit_branch_pkg::OP_INTERRUPT_DISABLE_INSTR,
      bit_branch_pkg::OP_LOCATION:
      begin
        taken_o = 1'b0;
      end
    endcase
  end

  always_comb
  begin
    ofs = bit_branch_pkg::OFS_OTHER;
    unique case (opd_i)
      bit_branch_pkg::OPD_SHORT_DIRECT:
        ofs = (modify_op ? bit_branch_pkg::OFS_SHORT_MODIFY : bit_branch_pkg::OFS_SHORT)
              + {2'b00, long_enc_i};
      bit_branch_pkg::OPD_SPECIAL_FUNC: ofs = bit_branch_pkg::OFS_SPECIAL;
      bit_branch_pkg::OPD_COUNT_B,
      bit_branch_pkg::OPD_COUNT_C: ofs = bit_branch_pkg::OFS_COUNT_REG;
      // absolute forms use 3 despite their longer encodings
      default: ofs = bit_branch_pkg::OFS_OTHER;
    endcase
  end

  assign target_o = pc_i + {{(bit_branch_pkg::PC_W-bit_branch_pkg::OFS_W){1'b0}}, ofs}
                    + {{(bit_branch_pkg::PC_W-8){disp_i[7]}}, disp_i};

endmodule

// ### test/bit_branch_asserts.sv
module bit_branch_asserts (
  input logic CLK_I,
  input logic SYS_RST_I,
  input logic INSTR_VALID_I,
  input bit_branch_pkg::instr_s INSTR_I,
  input logic INSTR_READY_O,
  input logic REG_WR_O,
  input logic MEM_REQ_O,
  input logic MEM_WE_O,
  input logic MEM_LOCK_O,
  input logic MEM_ACK_I,
  input logic [bit_branch_pkg::ADDR_W-1:0] MEM_ADDR_O,
  input logic STATUS_LOAD_I,
  input logic GLOBAL_INTERRUPT_ENABLE_O,
  input logic [2:0] REGISTER_BANK_FIELD_O,
  input logic ALT_REGISTER_SET_SELECT_O,
  input logic [bit_branch_pkg::LOC_W-1:0] LOCATION_WORD_O,
  input logic DONE_O,
  input logic BRANCH_TAKEN_O
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge CLK_I);
  endclocking
  default disable iff (SYS_RST_I);
  logic take;
  assign take = INSTR_VALID_I && INSTR_READY_O;
  // control ops never touch memory, so their answer time is fixed
  a_ctrl_done_time: assert property (take && INSTR_I.op inside {bit_branch_pkg::OP_BANK_SELECT,
    bit_branch_pkg::OP_BANK_SELECT_ALT, bit_branch_pkg::OP_LOCATION} |=> !DONE_O ##1 DONE_O)
    else $error("control op done at wrong cycle");
  a_ie_set: assert property (take && INSTR_I.op == bit_branch_pkg::OP_INTERRUPT_ENABLE_INSTR
    |-> ##2 GLOBAL_INTERRUPT_ENABLE_O)
    else $error("interrupt enable not set");
  a_ie_clear: assert property (take && INSTR_I.op == bit_branch_pkg::OP_INTERRUPT_DISABLE_INSTR
    |-> ##2 !GLOBAL_INTERRUPT_ENABLE_O)
    else $error("interrupt enable not cleared");
  a_bank_alt_load: assert property (take && INSTR_I.op == bit_branch_pkg::OP_BANK_SELECT_ALT
    |-> ##2 ALT_REGISTER_SET_SELECT_O && REGISTER_BANK_FIELD_O == $past(INSTR_I.bank, 2))
    else $error("alternate bank select wrong");
  a_bank_plain_load: assert property (take && INSTR_I.op == bit_branch_pkg::OP_BANK_SELECT
    |-> ##2 !ALT_REGISTER_SET_SELECT_O && REGISTER_BANK_FIELD_O == $past(INSTR_I.bank, 2))
    else $error("plain bank select wrong");
  a_location_load: assert property (take && INSTR_I.op == bit_branch_pkg::OP_LOCATION
    |-> ##2 LOCATION_WORD_O == $past(INSTR_I.loc, 2))
    else $error("location word not loaded");
  a_write_locked: assert property (MEM_REQ_O && MEM_WE_O |-> MEM_LOCK_O)
    else $error("memory write outside locked sequence");
  a_write_after_read: assert property ($rose(MEM_WE_O) |-> $past(MEM_LOCK_O) && MEM_LOCK_O)
    else $error("write not joined to its read");
  a_req_held: assert property (MEM_REQ_O && !MEM_ACK_I
    |=> MEM_REQ_O && $stable(MEM_ADDR_O) && $stable(MEM_WE_O))
    else $error("memory request dropped before ack");
  a_reg_write_done: assert property (REG_WR_O |-> DONE_O)
    else $error("register write apart from done");
  c_taken: cover property (DONE_O && BRANCH_TAKEN_O);
  c_mem_write: cover property (MEM_REQ_O && MEM_WE_O && MEM_ACK_I);
  c_status_load: cover property (STATUS_LOAD_I);
endmodule

// ### test/tb.sv
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_total++; \
  $display("wrong value at %0t: %h vs %h", $time, (a), (b)); end end
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [19:0] PC0 = 20'h01000;
  localparam logic [23:0] ADR0 = 24'h00FE20;
  localparam logic [7:0] DSP = 8'hF0;
  logic CLK_I, SYS_RST_I, INSTR_VALID_I, MEM_ACK_I, STATUS_LOAD_I;
  logic INSTR_READY_O, REG_WR_O, MEM_REQ_O, MEM_WE_O, MEM_LOCK_O, MEM_SFR_O;
  logic GLOBAL_INTERRUPT_ENABLE_O, ALT_REGISTER_SET_SELECT_O, DONE_O, BRANCH_TAKEN_O;
  bit_branch_pkg::instr_s INSTR_I;
  bit_branch_pkg::reg_sel_e REG_SEL_O;
  logic [7:0] REG_WR_DATA_O, MEM_WDATA_O, STATUS_WORD_LOW_O, STATUS_WORD_HIGH_O;
  logic [7:0] LOCATION_WORD_O, reg_byte, mem_byte, mw_d;
  logic [2:0] REGISTER_BANK_FIELD_O;
  logic [15:0] STATUS_LOAD_DATA_I;
  logic [19:0] NEXT_PC_O;
  logic [23:0] MEM_ADDR_O;
  wire logic [7:0] REG_RD_DATA_I;
  wire logic [7:0] MEM_RDATA_I;
  int err_total, check_count, mw_n, wt, lat;
  // data line shows garbage outside the ack cycle
  assign MEM_RDATA_I = MEM_ACK_I ? mem_byte : ~mem_byte;
  assign REG_RD_DATA_I = reg_byte;
  bit_branch_cpu_control u_bit_branch_cpu_control (
    .CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I), .INSTR_VALID_I(INSTR_VALID_I), .INSTR_I(INSTR_I),
    .INSTR_READY_O(INSTR_READY_O), .REG_SEL_O(REG_SEL_O), .REG_RD_DATA_I(REG_RD_DATA_I),
    .REG_WR_O(REG_WR_O), .REG_WR_DATA_O(REG_WR_DATA_O), .MEM_REQ_O(MEM_REQ_O),
    .MEM_WE_O(MEM_WE_O), .MEM_LOCK_O(MEM_LOCK_O), .MEM_SFR_O(MEM_SFR_O),
    .MEM_ADDR_O(MEM_ADDR_O), .MEM_WDATA_O(MEM_WDATA_O), .MEM_RDATA_I(MEM_RDATA_I),
    .MEM_ACK_I(MEM_ACK_I), .STATUS_LOAD_I(STATUS_LOAD_I),
    .STATUS_LOAD_DATA_I(STATUS_LOAD_DATA_I), .STATUS_WORD_LOW_O(STATUS_WORD_LOW_O),
    .STATUS_WORD_HIGH_O(STATUS_WORD_HIGH_O),
    .GLOBAL_INTERRUPT_ENABLE_O(GLOBAL_INTERRUPT_ENABLE_O),
    .REGISTER_BANK_FIELD_O(REGISTER_BANK_FIELD_O),
    .ALT_REGISTER_SET_SELECT_O(ALT_REGISTER_SET_SELECT_O),
    .LOCATION_WORD_O(LOCATION_WORD_O), .DONE_O(DONE_O), .BRANCH_TAKEN_O(BRANCH_TAKEN_O),
    .NEXT_PC_O(NEXT_PC_O)
  );
  initial
  begin
    CLK_I = 0;
    forever #2.5 CLK_I = ~CLK_I;
  end
  task complete_run;
    if (err_total == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // ack after lat wait cycles, then drop for one cycle
  always @(posedge CLK_I)
  begin
    #1;
    if (MEM_REQ_O && !MEM_ACK_I && wt >= lat)
    begin
      MEM_ACK_I = 1;
      wt = 0;
      `CHK(MEM_ADDR_O, ADR0);
    end
    else
    begin
      MEM_ACK_I = 0;
      if (MEM_REQ_O)
        wt++;
    end
  end
  always @(negedge CLK_I)
    if (MEM_REQ_O && MEM_WE_O && MEM_ACK_I)
    begin
      mw_n++;
      mw_d = MEM_WDATA_O;
    end
  // we: bit 0 register write, bit 1 memory write
  task automatic run(input int op, opd, input logic lg, input logic [2:0] b, len,
    input logic [7:0] loc, rd, input logic tk, input int ofs, input logic [1:0] we,
    input logic [7:0] wd);
    int n;
    logic [19:0] ex;
    logic [1:0] rs;
    ex = tk ? PC0 + 20'(ofs) + {{12{DSP[7]}}, DSP} : PC0 + 20'(len);
    // register port select: X, A, B, C; A when no register operand
    rs = (opd == 2) ? 2'h0 : (opd == 9) ? 2'h2 : (opd == 10) ? 2'h3 : 2'h1;
    reg_byte = rd;
    mem_byte = rd;
    mw_n = 0;
    n = 0;
    INSTR_I = '{bit_branch_pkg::op_e'(op), bit_branch_pkg::opd_e'(opd), lg, b, len, DSP,
      ADR0, PC0, loc[2:0], loc};
    INSTR_VALID_I = 1;
    @(posedge CLK_I);
    #1 INSTR_VALID_I = 0;
    while (DONE_O !== 1'b1 && n < 40)
    begin
      @(posedge CLK_I);
      #1 n++;
    end
    `CHK(DONE_O, 1'b1);
    `CHK(BRANCH_TAKEN_O, tk);
    `CHK(NEXT_PC_O, ex);
    `CHK(REG_WR_O, we[0]);
    if (we[0])
      `CHK(REG_WR_DATA_O, wd);
    `CHK(mw_n == 1, we[1]);
    if (we[1])
      `CHK(mw_d, wd);
    `CHK(REG_SEL_O, rs);
    `CHK(MEM_SFR_O, opd == 1);
  endtask
  initial
  begin
    SYS_RST_I = 1;
    INSTR_VALID_I = 0;
    INSTR_I = '0;
    MEM_ACK_I = 0;
    STATUS_LOAD_I = 0;
    STATUS_LOAD_DATA_I = 16'h0000;
    reg_byte = 8'h00;
    mem_byte = 8'h00;
    {err_total, check_count, mw_n, wt, lat} = '0;
    repeat (3) @(posedge CLK_I);
    #1 SYS_RST_I = 0;
    `CHK({STATUS_WORD_HIGH_O, STATUS_WORD_LOW_O, LOCATION_WORD_O, DONE_O}, 25'h0);
    `CHK({GLOBAL_INTERRUPT_ENABLE_O, ALT_REGISTER_SET_SELECT_O, INSTR_READY_O}, 3'h1);
    run(0, 0, 0, 3, 3, 0, 8'h08, 1, 3, 0, 0);
    run(0, 0, 1, 3, 4, 0, 8'h08, 1, 4, 0, 0);
    run(0, 1, 0, 0, 4, 0, 8'h01, 1, 4, 0, 0);
    run(0, 1, 0, 0, 4, 0, 8'hFE, 0, 4, 0, 0);
    run(0, 2, 0, 7, 3, 0, 8'h80, 1, 3, 0, 0);
    run(0, 3, 0, 1, 3, 0, 8'hFD, 0, 3, 0, 0);
    run(0, 6, 0, 6, 6, 0, 8'h40, 1, 3, 0, 0);
    run(0, 7, 0, 5, 3, 0, 8'h20, 1, 3, 0, 0);
    run(0, 8, 0, 2, 3, 0, 8'h04, 1, 3, 0, 0);
    run(1, 3, 0, 0, 3, 0, 8'h00, 1, 3, 0, 0);
    lat = 2;
    run(2, 0, 1, 7, 5, 0, 8'h81, 1, 5, 2, 8'h01);
    run(2, 0, 0, 0, 4, 0, 8'h80, 0, 4, 0, 0);
    run(2, 1, 0, 1, 4, 0, 8'h02, 1, 4, 2, 8'h00);
    run(3, 0, 0, 4, 4, 0, 8'h00, 1, 4, 2, 8'h10);
    run(3, 0, 1, 4, 5, 0, 8'h10, 0, 5, 0, 0);
    run(3, 1, 0, 0, 4, 0, 8'hFE, 1, 4, 2, 8'hFF);
    run(4, 0, 1, 0, 4, 0, 8'h03, 1, 4, 2, 8'h02);
    run(4, 0, 0, 0, 3, 0, 8'h01, 0, 3, 2, 8'h00);
    lat = 0;
    run(2, 2, 0, 5, 3, 0, 8'hFF, 1, 3, 1, 8'hDF);
    run(3, 3, 0, 3, 3, 0, 8'h00, 1, 3, 1, 8'h08);
    run(4, 9, 0, 0, 2, 0, 8'h05, 1, 2, 1, 8'h04);
    run(4, 10, 0, 0, 2, 0, 8'h01, 0, 2, 1, 8'h00);
    `CHK(REG_SEL_O, bit_branch_pkg::REG_C);
    STATUS_LOAD_DATA_I = 16'h0480;
    STATUS_LOAD_I = 1;
    @(posedge CLK_I);
    #1 STATUS_LOAD_I = 0;
    run(0, 4, 0, 7, 3, 0, 0, 1, 3, 0, 0);
    run(2, 5, 0, 2, 3, 0, 0, 1, 3, 0, 0);
    `CHK(STATUS_WORD_HIGH_O, 8'h00);
    run(3, 5, 0, 7, 3, 0, 0, 1, 3, 0, 0);
    `CHK(STATUS_WORD_HIGH_O, 8'h80);
    run(2, 4, 0, 7, 3, 0, 0, 1, 3, 0, 0);
    `CHK(STATUS_WORD_LOW_O, 8'h00);
    run(3, 4, 0, 0, 3, 0, 0, 1, 3, 0, 0);
    `CHK(STATUS_WORD_LOW_O, 8'h01);
    run(6, 0, 0, 0, 2, 8'h05, 0, 0, 0, 0, 0);
    `CHK({ALT_REGISTER_SET_SELECT_O, REGISTER_BANK_FIELD_O}, 4'hD);
    run(5, 0, 0, 0, 2, 8'h02, 0, 0, 0, 0, 0);
    `CHK({ALT_REGISTER_SET_SELECT_O, REGISTER_BANK_FIELD_O}, 4'h2);
    run(7, 0, 0, 0, 1, 0, 0, 0, 0, 0, 0);
    `CHK(GLOBAL_INTERRUPT_ENABLE_O, 1'b1);
    run(8, 0, 0, 0, 1, 0, 0, 0, 0, 0, 0);
    `CHK(GLOBAL_INTERRUPT_ENABLE_O, 1'b0);
    run(9, 0, 0, 0, 4, 8'hA5, 0, 0, 0, 0, 0);
    `CHK(LOCATION_WORD_O, 8'hA5);
    complete_run();
  end
  initial
  begin
    #20000;
    err_total++;
    complete_run();
  end
endmodule
bind bit_branch_cpu_control bit_branch_asserts u_bit_branch_asserts (
  .CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I), .INSTR_VALID_I(INSTR_VALID_I), .INSTR_I(INSTR_I),
  .INSTR_READY_O(INSTR_READY_O), .REG_WR_O(REG_WR_O), .MEM_REQ_O(MEM_REQ_O),
  .MEM_WE_O(MEM_WE_O), .MEM_LOCK_O(MEM_LOCK_O), .MEM_ACK_I(MEM_ACK_I),
  .MEM_ADDR_O(MEM_ADDR_O), .STATUS_LOAD_I(STATUS_LOAD_I),
  .GLOBAL_INTERRUPT_ENABLE_O(GLOBAL_INTERRUPT_ENABLE_O),
  .REGISTER_BANK_FIELD_O(REGISTER_BANK_FIELD_O),
  .ALT_REGISTER_SET_SELECT_O(ALT_REGISTER_SET_SELECT_O),
  .LOCATION_WORD_O(LOCATION_WORD_O), .DONE_O(DONE_O), .BRANCH_TAKEN_O(BRANCH_TAKEN_O)
);
